//--- src/cua_map.svh
// Register offsets, reset values and timing counts of the UART
`ifndef CUA_MAP_SVH
`define CUA_MAP_SVH
`define CUA_OFF_CTRL 12'h000
`define CUA_OFF_TXDATA 12'h004
`define CUA_OFF_RXDATA 12'h008
`define CUA_OFF_RXSTAT 12'h00c
`define CUA_OFF_TXSTAT 12'h010
`define CUA_OFF_RXMASK 12'h014
`define CUA_OFF_TXMASK 12'h018
`define CUA_OFF_ADDR 12'h01c
`define CUA_OFF_BREAK 12'h020
`define CUA_CTRL_RST 8'h0
`define CUA_RXMASK_RST 7'h01
`define CUA_TXMASK_RST 4'h0
`define CUA_ADDR1_RST 8'h01
`define CUA_ADDR2_RST 8'h02
`define CUA_BREAK_RST 5'h0d
`define CUA_OVS 5'h10
`define CUA_OVS_MID 5'h07
`define CUA_OVS_A 5'h06
`define CUA_OVS_C 5'h08
`define CUA_FIFO_DEPTH 3'h4
`define CUA_BITS_DEF 4'h8
`define CUA_RX_BRK_MIN 4'ha
`endif

//--- src/cua_pkg.sv
// Types shared by the UART design
package cua_pkg;
  // Build variants
  typedef enum logic [1:0] {CUA_FULL, CUA_HALF, CUA_RXONLY, CUA_TXONLY} cua_mode_type;
  // Address handling modes
  typedef enum logic [2:0] {CUA_ADR_NONE, CUA_ADR_SWBYTE, CUA_ADR_SWBUF, CUA_ADR_HWBYTE,
                            CUA_ADR_HWBUF} cua_adr_type;
  // Parity kinds
  typedef enum logic [1:0] {CUA_PAR_NONE, CUA_PAR_ODD, CUA_PAR_EVEN, CUA_PAR_MS} cua_par_type;
  typedef enum logic [2:0] {CUA_TX_IDLE, CUA_TX_START, CUA_TX_DATA, CUA_TX_PAR, CUA_TX_STOP,
                            CUA_TX_BRK} cua_tx_state_type;
  typedef enum logic [2:0] {CUA_RX_IDLE, CUA_RX_START, CUA_RX_DATA, CUA_RX_PAR, CUA_RX_STOP
                            } cua_rx_state_type;
endpackage

//--- src/cua_uart.sv
// Configurable UART with address detect, APB registers, FIFOs and status outputs
`timescale 1ns/1ps
`include "cua_map.svh"

// Contract
// - Full, half, receive-only or transmit-only build
// - Five to nine data bits, default eight
// - Nine-bit mode sends address flag with no or mark/space parity
// - Parity none, odd, even or mark/space
// - Parity changeable by control write
// - One or two stop bits
// - Flow control pins only when selected
// - Software mode flags every address character
// - Hardware byte mode keeps matched address
// - Detect-to-buffer stores only addressed data
// - Two addresses, second absent half duplex
// - Break generation and detection
// - Two of three sample voting
// - CRC taps strobe only data bits
// - Driver enable from transmit buffer
// - Receive and transmit status sources
// - Interrupt is OR of enabled sources
// - Interrupt outputs usable as DMA requests
// - Four-deep FIFO each direction
// - Half duplex has no transmit interrupt
// - Bit rate is clock over oversampling
// - Synchronous reset idles both machines
// - Request-to-send high when receive full
// - Driver enable brackets the transmission
module cua_uart import cua_pkg::*; #(
  parameter cua_mode_type MODE = CUA_FULL,
  parameter cua_adr_type ADR_MODE = CUA_ADR_NONE,
  parameter bit FLOW_HW = 1'b0,
  parameter bit BREAK_EN = 1'b1,
  parameter bit VOTE_EN = 1'b1,
  parameter bit CRC_EN = 1'b1,
  parameter bit TXEN_HW = 1'b1,
  parameter bit PAR_API = 1'b1,
  parameter cua_par_type PAR_DEF = CUA_PAR_NONE,
  parameter logic [3:0] DATA_BITS = `CUA_BITS_DEF,
  parameter bit TWO_STOP = 1'b0
) (
  // Clock, asynchronous and synchronous resets
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sync_reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial line and flow control
  input wire logic rx,
  output logic tx,
  input wire logic cts_n,
  output logic rts_n,
  output logic tx_en,
  // Interrupts
  output logic rx_interrupt,
  output logic tx_interrupt,
  // CRC taps
  output logic tx_data,
  output logic tx_clk,
  output logic rx_data,
  output logic rx_clk
);
  localparam bit HAS_TX = (MODE != CUA_RXONLY);
  localparam bit HAS_RX = (MODE != CUA_TXONLY);
  localparam bit HAS_A2 = (MODE != CUA_HALF);

  typedef struct packed {
    logic [7:0] ctrl;          // [1:0] parity, [2] tx address flag
    logic [6:0] rx_mask;
    logic [3:0] tx_mask;
    logic [7:0] addr1;
    logic [7:0] addr2;
    logic [4:0] brk_len;
    logic [3:0][8:0] txf;
    logic [1:0] txw;
    logic [1:0] txr;
    logic [2:0] txc;
    logic [3:0][7:0] rxf;
    logic [1:0] rxw;
    logic [1:0] rxr;
    logic [2:0] rxc;
    cua_tx_state_type ts;
    logic [4:0] tdiv;
    logic [3:0] tbit;
    logic [8:0] tsh;
    logic tpar;
    logic brk_req;
    logic tx_line;
    logic tx_done;
    logic tclk;
    cua_rx_state_type rs;
    logic [4:0] rdiv;
    logic [3:0] rbit;
    logic [8:0] rsh;
    logic rpar;
    logic s0;
    logic s1;
    logic [3:0] zcnt;
    logic addressed;
    logic [4:0] rx_st;         // parity, stop, break, match, address sticky bits
    logic rclk;
    logic [31:0] rdat;
  } cua_state_type;

  cua_state_type st_reg, st_next;
  logic acc, wr, rd;
  logic samp, voted;
  logic [6:0] rx_src;
  logic [3:0] tx_src;
  logic ovr_reg, ovr_next;

  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;

  // Two of three vote over the sampled bit
  always_comb begin
    voted = VOTE_EN ? ((st_reg.s0 & st_reg.s1) | (st_reg.s0 & rx) | (st_reg.s1 & rx)) : rx;
  end

  // Status sources
  always_comb begin
    // status sources
    // Overrun, parity, stop, break, hit, address seen, not empty
    rx_src = {ovr_reg, st_reg.rx_st, (st_reg.rxc != 3'h0)};
    tx_src = {(st_reg.txc != `CUA_FIFO_DEPTH), (st_reg.txc == `CUA_FIFO_DEPTH),
              (st_reg.txc == 3'h0), st_reg.tx_done};
  end

  // Next-state logic
  always_comb begin
    logic [8:0] cd;
    logic push_rx, keep, is_addr, hit, par_ok;
    logic [3:0] nbits;
    cd = '0;
    samp = 1'b0;
    push_rx = 1'b0;
    keep = 1'b0;
    is_addr = 1'b0;
    hit = 1'b0;
    par_ok = 1'b1;
    // nine-bit mode sends eight data bits plus address flag or odd/even parity bit
    nbits = (DATA_BITS == 4'h9) ? 4'h8 : DATA_BITS;
    st_next = st_reg;
    st_next.tclk = 1'b0;
    st_next.rclk = 1'b0;
    st_next.s0 = rx;
    st_next.s1 = st_reg.s0;
    // Register writes
    if (wr) begin
      case (paddr)
        `CUA_OFF_CTRL: st_next.ctrl = PAR_API ? pwdata[7:0] : {st_reg.ctrl[7:2], PAR_DEF};
        `CUA_OFF_TXDATA: if (HAS_TX && st_reg.txc != `CUA_FIFO_DEPTH) begin
          st_next.txf[st_reg.txw] = {st_reg.ctrl[2], pwdata[7:0]};
          st_next.txw = st_reg.txw + 2'h1;
          st_next.txc = st_next.txc + 3'h1;
        end
        `CUA_OFF_RXMASK: st_next.rx_mask = pwdata[6:0];
        `CUA_OFF_TXMASK: st_next.tx_mask = pwdata[3:0];
        `CUA_OFF_ADDR: begin
          st_next.addr1 = pwdata[7:0];
          // second address absent in half duplex
          st_next.addr2 = HAS_A2 ? pwdata[15:8] : 8'h0;
        end
        `CUA_OFF_BREAK: if (BREAK_EN) begin
          st_next.brk_len = pwdata[4:0];
          st_next.brk_req = 1'b1;
        end
        default: ;
      endcase
    end
    // Register reads, with side effects
    st_next.rdat = 32'h0;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        `CUA_OFF_CTRL: st_next.rdat = {24'h0, st_reg.ctrl};
        `CUA_OFF_RXDATA: st_next.rdat = {24'h0, st_reg.rxf[st_reg.rxr]};
        `CUA_OFF_RXSTAT: st_next.rdat = {25'h0, rx_src};
        `CUA_OFF_TXSTAT: st_next.rdat = {28'h0, tx_src};
        `CUA_OFF_RXMASK: st_next.rdat = {25'h0, st_reg.rx_mask};
        `CUA_OFF_TXMASK: st_next.rdat = {28'h0, st_reg.tx_mask};
        `CUA_OFF_ADDR: st_next.rdat = {16'h0, st_reg.addr2, st_reg.addr1};
        `CUA_OFF_BREAK: st_next.rdat = {27'h0, st_reg.brk_len};
        default: st_next.rdat = 32'h0;
      endcase
    end
    if (rd && paddr == `CUA_OFF_RXDATA && st_reg.rxc != 3'h0) begin
      st_next.rxr = st_reg.rxr + 2'h1;
      st_next.rxc = st_next.rxc - 3'h1;
    end
    // Reading status clears only the sticky bits that the read reported
    if (rd && paddr == `CUA_OFF_RXSTAT) st_next.rx_st = st_reg.rx_st & ~st_reg.rdat[5:1];
    if (rd && paddr == `CUA_OFF_TXSTAT) st_next.tx_done = st_reg.tx_done & ~st_reg.rdat[0];

    // Transmitter, one bit per oversampling period
    if (HAS_TX) begin
      st_next.tdiv = (st_reg.tdiv == `CUA_OVS - 5'h1) ? 5'h0 : st_reg.tdiv + 5'h1;
      case (st_reg.ts)
        CUA_TX_IDLE: begin
          st_next.tx_line = 1'b1;
          st_next.tdiv = 5'h0;
          if (st_reg.brk_req) begin
            st_next.ts = CUA_TX_BRK;
            st_next.tbit = 4'h0;
            st_next.brk_req = 1'b0;
          end else if (st_reg.txc != 3'h0 && !(FLOW_HW && cts_n)) begin
            st_next.tsh = st_reg.txf[st_reg.txr];
            st_next.txr = st_reg.txr + 2'h1;
            st_next.txc = st_next.txc - 3'h1;
            st_next.ts = CUA_TX_START;
          end
        end
        CUA_TX_START: begin
          st_next.tx_line = 1'b0;
          st_next.tbit = 4'h0;
          st_next.tpar = 1'b0;
          if (st_reg.tdiv == `CUA_OVS - 5'h1) st_next.ts = CUA_TX_DATA;
        end
        CUA_TX_DATA: begin
          st_next.tx_line = st_reg.tsh[st_reg.tbit];
          st_next.tclk = (st_reg.tdiv >= `CUA_OVS_MID);
          if (st_reg.tdiv == `CUA_OVS - 5'h1) begin
            st_next.tpar = st_reg.tpar ^ st_reg.tsh[st_reg.tbit];
            st_next.tbit = st_reg.tbit + 4'h1;
            if (st_reg.tbit == nbits - 4'h1) begin
              st_next.tbit = 4'h0;
              st_next.ts = (st_reg.ctrl[1:0] == CUA_PAR_NONE && DATA_BITS != 4'h9) ?
                           CUA_TX_STOP : CUA_TX_PAR;
            end
          end
        end
        CUA_TX_PAR: begin
          case (cua_par_type'(st_reg.ctrl[1:0]))
            CUA_PAR_ODD: st_next.tx_line = ~st_reg.tpar;
            CUA_PAR_EVEN: st_next.tx_line = st_reg.tpar;
            default: st_next.tx_line = st_reg.tsh[8];
          endcase
          if (st_reg.tdiv == `CUA_OVS - 5'h1) st_next.ts = CUA_TX_STOP;
        end
        CUA_TX_STOP: begin
          st_next.tx_line = 1'b1;
          if (st_reg.tdiv == `CUA_OVS - 5'h1) begin
            st_next.tbit = st_reg.tbit + 4'h1;
            if (st_reg.tbit == {3'h0, TWO_STOP}) begin
              st_next.ts = CUA_TX_IDLE;
              st_next.tx_done = 1'b1;
            end
          end
        end
        CUA_TX_BRK: begin
          // zeros for the programmed bit count
          st_next.tx_line = 1'b0;
          if (st_reg.tdiv == `CUA_OVS - 5'h1) begin
            st_next.tbit = st_reg.tbit + 4'h1;
            if ({1'b0, st_reg.tbit} >= st_reg.brk_len - 5'h1) begin
              st_next.ts = CUA_TX_STOP;
              st_next.tbit = {3'h0, TWO_STOP};
            end
          end
        end
        default: st_next.ts = CUA_TX_IDLE;
      endcase
    end

    // Receiver
    if (HAS_RX) begin
      st_next.rdiv = (st_reg.rdiv == `CUA_OVS - 5'h1) ? 5'h0 : st_reg.rdiv + 5'h1;
      samp = (st_reg.rdiv == `CUA_OVS_C);
      case (st_reg.rs)
        CUA_RX_IDLE: begin
          st_next.rdiv = 5'h0;
          if (!st_reg.s0) st_next.rs = CUA_RX_START;
        end
        CUA_RX_START: if (samp) begin
          st_next.rbit = 4'h0;
          st_next.rpar = 1'b0;
          st_next.zcnt = 4'h1;
          st_next.rs = voted ? CUA_RX_IDLE : CUA_RX_DATA;
        end
        CUA_RX_DATA: if (samp) begin
          st_next.rsh[st_reg.rbit] = voted;
          st_next.rpar = st_reg.rpar ^ voted;
          // receive tap strobe on data bits only
          st_next.rclk = 1'b1;
          st_next.rbit = st_reg.rbit + 4'h1;
          if (!voted && st_reg.zcnt != 4'hf) st_next.zcnt = st_reg.zcnt + 4'h1;
          if (st_reg.rbit == nbits - 4'h1) begin
            st_next.rs = (st_reg.ctrl[1:0] == CUA_PAR_NONE && DATA_BITS != 4'h9) ?
                         CUA_RX_STOP : CUA_RX_PAR;
          end
        end
        CUA_RX_PAR: if (samp) begin
          st_next.rsh[8] = voted;
          if (!voted && st_reg.zcnt != 4'hf) st_next.zcnt = st_reg.zcnt + 4'h1;
          st_next.rs = CUA_RX_STOP;
        end
        CUA_RX_STOP: if (samp) begin
          st_next.rs = CUA_RX_IDLE;
          cd = st_reg.rsh;
          if (nbits < 4'h8) cd[8:0] = st_reg.rsh & ~(9'h1ff << nbits);
          case (cua_par_type'(st_reg.ctrl[1:0]))
            CUA_PAR_ODD: par_ok = (st_reg.rpar ^ st_reg.rsh[8]);
            CUA_PAR_EVEN: par_ok = !(st_reg.rpar ^ st_reg.rsh[8]);
            default: par_ok = 1'b1;
          endcase
          is_addr = (st_reg.ctrl[1:0] == CUA_PAR_MS) && st_reg.rsh[8];
          hit = is_addr && (cd[7:0] == st_reg.addr1 || (HAS_A2 && cd[7:0] == st_reg.addr2));
          case (ADR_MODE)
            CUA_ADR_HWBYTE: begin
              if (is_addr) st_next.addressed = hit;
              keep = is_addr ? hit : st_reg.addressed;
            end
            CUA_ADR_HWBUF: begin
              if (is_addr) st_next.addressed = hit;
              keep = !is_addr && st_reg.addressed;
            end
            default: keep = 1'b1;
          endcase
          if (is_addr && (ADR_MODE == CUA_ADR_SWBYTE || ADR_MODE == CUA_ADR_SWBUF ||
              keep)) st_next.rx_st[0] = 1'b1;
          if (hit) st_next.rx_st[1] = 1'b1;
          // stop error on low stop bit, break on long zero run
          // The low stop bit itself completes the zero count
          if (!voted && st_reg.zcnt >= `CUA_RX_BRK_MIN - 4'h1 && BREAK_EN) begin
            st_next.rx_st[2] = 1'b1;
            keep = 1'b0;
          end else if (!voted) begin
            st_next.rx_st[3] = 1'b1;
          end
          if (!par_ok && keep) st_next.rx_st[4] = 1'b1;
          push_rx = keep;
        end
        default: st_next.rs = CUA_RX_IDLE;
      endcase
      // push into four-deep FIFO or flag overrun
      if (push_rx) begin
        if (st_next.rxc == `CUA_FIFO_DEPTH) begin
          // FIFO full: character dropped, overrun flagged in its own process
          st_next.zcnt = 4'h0;
        end else begin
          st_next.rxf[st_reg.rxw] = cd[7:0];
          st_next.rxw = st_reg.rxw + 2'h1;
          st_next.rxc = st_next.rxc + 3'h1;
        end
      end
    end
    // synchronous reset idles both machines and drops the character
    if (sync_reset) begin
      st_next.ts = CUA_TX_IDLE;
      st_next.rs = CUA_RX_IDLE;
      st_next.tx_line = 1'b1;
      st_next.brk_req = 1'b0;
    end
  end

  // Overrun sticky flag kept apart to keep the push path simple
  always_comb begin
    ovr_next = ovr_reg;
    if (rd && paddr == `CUA_OFF_RXSTAT) ovr_next = ovr_reg & ~st_reg.rdat[6];
    // overrun when FIFO full at completion; set wins over clear
    if (HAS_RX && st_reg.rs == CUA_RX_STOP && st_reg.rdiv == `CUA_OVS_C && st_next.rxc ==
        `CUA_FIFO_DEPTH && st_next.rxw == st_reg.rxw && st_next.rs == CUA_RX_IDLE &&
        st_reg.rxc == `CUA_FIFO_DEPTH && !(rd && paddr == `CUA_OFF_RXDATA)) ovr_next = 1'b1;
  end

  // State registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.ctrl <= `CUA_CTRL_RST;
      st_reg.rx_mask <= `CUA_RXMASK_RST;
      st_reg.tx_mask <= `CUA_TXMASK_RST;
      st_reg.addr1 <= `CUA_ADDR1_RST;
      st_reg.addr2 <= `CUA_ADDR2_RST;
      st_reg.brk_len <= `CUA_BREAK_RST;
      st_reg.tx_line <= 1'b1;
      st_reg.s0 <= 1'b1;
      st_reg.s1 <= 1'b1;
      ovr_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      ovr_reg <= ovr_next;
    end
  end

  // Outputs
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = st_reg.rdat;
  assign tx = st_reg.tx_line;
  // request-to-send high when receive FIFO full
  assign rts_n = FLOW_HW ? (st_reg.rxc == `CUA_FIFO_DEPTH) : 1'b0;
  // driver enable while queue or shifter busy
  assign tx_en = TXEN_HW && (st_reg.ts != CUA_TX_IDLE || st_reg.txc != 3'h0);
  // interrupt is OR of enabled sources; no transmit interrupt in half duplex
  assign rx_interrupt = HAS_RX && |(rx_src & st_reg.rx_mask);
  assign tx_interrupt = (MODE == CUA_FULL || MODE == CUA_TXONLY) && |(tx_src & st_reg.tx_mask);
  assign tx_data = CRC_EN && st_reg.tx_line;
  assign tx_clk = CRC_EN && st_reg.tclk;
  assign rx_data = CRC_EN && st_reg.rsh[st_reg.rbit == 4'h0 ? 4'h0 : st_reg.rbit - 4'h1];
  assign rx_clk = CRC_EN && st_reg.rclk;

  chk_tx_start_low: assert property (@(posedge clk) disable iff (!rst_n)
    st_reg.ts == CUA_TX_START && !sync_reset |=> !tx) else $error("start bit not low");
  chk_rts_full: assert property (@(posedge clk) disable iff (!rst_n)
    FLOW_HW && st_reg.rxc == `CUA_FIFO_DEPTH |-> rts_n) else $error("rts not high");
  chk_txen_busy: assert property (@(posedge clk) disable iff (!rst_n)
    TXEN_HW && st_reg.ts != CUA_TX_IDLE |-> tx_en) else $error("tx_en low in frame");
  chk_fifo_depth: assert property (@(posedge clk) disable iff (!rst_n)
    st_reg.rxc <= `CUA_FIFO_DEPTH && st_reg.txc <= `CUA_FIFO_DEPTH) else $error("fifo");
  chk_sreset_idle: assert property (@(posedge clk) disable iff (!rst_n)
    sync_reset |=> st_reg.rs == CUA_RX_IDLE && tx) else $error("reset not idle");
  chk_cts_wait: assert property (@(posedge clk) disable iff (!rst_n)
    FLOW_HW && cts_n && st_reg.ts == CUA_TX_IDLE && !st_reg.brk_req && !sync_reset
    |=> st_reg.ts == CUA_TX_IDLE) else $error("sent while cts high");
  chk_tclk_data: assert property (@(posedge clk) disable iff (!rst_n)
    tx_clk |-> $past(st_reg.ts) == CUA_TX_DATA) else $error("strobe outside data");
  chk_rx_irq_or: assert property (@(posedge clk) disable iff (!rst_n)
    HAS_RX && st_reg.rx_mask[0] && st_reg.rxc != 3'h0 |-> rx_interrupt)
    else $error("irq missing");
endmodule

//--- bench/cua_far_end.sv
// Remote serial party: sends frames into the UART and collects its output
`timescale 1ns/1ps
module cua_far_end (
  // Clock
  input wire logic clk,
  // Serial line
  input wire logic tx,
  output logic rx
);
  logic [7:0] got[$];
  logic [7:0] v;
  // Line idles high
  initial rx = 1'b1;
  // One bit time of 16 clocks
  task bit_out(input logic b);
    rx <= b;
    repeat (16) @(posedge clk);
  endtask
  task send(input logic [7:0] d, input logic [1:0] par, input bit bad, input bit stp);
    bit_out(1'b0);
    for (int i = 0; i < 8; i++) bit_out(d[i]);
    if (par != 2'h0) bit_out((par == 2'h2 ? ^d : ~^d) ^ bad);
    bit_out(stp);
    bit_out(1'b1);
  endtask
  // line held low for twelve bit times
  task brk();
    repeat (12) bit_out(1'b0);
    bit_out(1'b1);
  endtask
  // sample the UART output mid-bit, LSB first
  initial begin
    forever begin
      @(negedge tx);
      repeat (8) @(posedge clk);
      if (tx === 1'b0) begin
        repeat (8) begin
          repeat (16) @(posedge clk);
          v = {tx, v[7:1]};
        end
        repeat (16) @(posedge clk);
        got.push_back(v);
      end
    end
  end
endmodule

//--- bench/tb_top.sv
// Self-checking bench for the configurable UART
`timescale 1ns/1ps
`include "cua_map.svh"
module tb_top;
  logic clk, rst_n, sync_reset, psel, penable, pwrite, cts_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, rx, tx, rts_n, tx_en, rx_interrupt, tx_interrupt, tx_clk, rx_clk;
  logic [7:0] b[5];
  int fail_count, compares, rclk_n, tclk_n;
  // Design under test, default build with hardware flow control
  cua_uart #(.FLOW_HW(1'b1)) DUT (.clk(clk), .rst_n(rst_n), .sync_reset(sync_reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx(rx), .tx(tx), .cts_n(cts_n), .rts_n(rts_n),
    .tx_en(tx_en), .rx_interrupt(rx_interrupt), .tx_interrupt(tx_interrupt),
    .tx_data(), .tx_clk(tx_clk), .rx_data(), .rx_clk(rx_clk));
  // Remote party on the serial line
  cua_far_end far (.clk(clk), .tx(tx), .rx(rx));
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Count CRC strobe edges
  always @(posedge rx_clk) rclk_n++;
  always @(posedge tx_clk) tclk_n++;
  // Compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // One APB transfer, read data kept in rd
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // Print counts and the verdict, then stop
  task give_verdict();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    #300000;
    fail_count++;
    give_verdict();
  end
  // Test sequence
  initial begin
    rst_n = 1'b0;
    sync_reset = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    cts_n = 1'b0;
    void'($urandom(36661));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // Reset values, unmapped place, transmit mask
    apb(1'b0, `CUA_OFF_RXMASK, 32'h0);
    chk(rd, 32'h01, "rx mask");
    apb(1'b0, `CUA_OFF_ADDR, 32'h0);
    chk(rd & 32'hffff, 32'h0201, "addresses");
    apb(1'b0, 12'h0fc, 32'h0);
    chk(rd, 32'h0, "unmapped");
    apb(1'b0, `CUA_OFF_TXSTAT, 32'h0);
    chk(rd & 32'he, 32'ha, "tx status");
    apb(1'b1, `CUA_OFF_TXMASK, 32'h2);
    chk(tx_interrupt, 1'b1, "tx irq on");
    apb(1'b1, `CUA_OFF_TXMASK, 32'h0);
    chk(tx_interrupt, 1'b0, "tx irq off");
    $display("test registers done");
    // Four random characters back to back
    tclk_n = 0;
    for (int i = 0; i < 4; i++) begin
      b[i] = 8'($urandom);
      apb(1'b1, `CUA_OFF_TXDATA, {24'h0, b[i]});
    end
    chk(tx_en, 1'b1, "driver enable on");
    for (int k = 0; k < 20000 && far.got.size() < 4; k++) @(posedge clk);
    repeat (40) @(posedge clk);
    for (int i = 0; i < 4; i++) chk(far.got[i], b[i], "tx char");
    chk(tclk_n, 32, "tx strobes");
    chk(tx_en, 1'b0, "driver enable off");
    apb(1'b0, `CUA_OFF_TXSTAT, 32'h0);
    chk(rd & 32'h3, 32'h3, "tx done");
    far.got.delete();
    $display("test transmit done");
    // odd and even parity, good and corrupted
    for (int p = 1; p < 3; p++) begin
      apb(1'b1, `CUA_OFF_CTRL, 32'(p));
      for (int e = 0; e < 2; e++) begin
        b[0] = 8'($urandom);
        rclk_n = 0;
        far.send(b[0], 2'(p), e, 1'b1);
        apb(1'b0, `CUA_OFF_RXSTAT, 32'h0);
        chk(rd & 32'h21, e ? 32'h21 : 32'h01, "parity");
        apb(1'b0, `CUA_OFF_RXDATA, 32'h0);
        chk(rd & 32'hff, b[0], "rx char");
        chk(rclk_n, 8, "rx strobes");
      end
    end
    apb(1'b1, `CUA_OFF_CTRL, 32'h0);
    $display("test parity done");
    // Stop error through a masked source, then a break
    apb(1'b1, `CUA_OFF_RXMASK, 32'h10);
    far.send(8'h55, 2'h0, 1'b0, 1'b0);
    chk(rx_interrupt, 1'b1, "stop irq");
    apb(1'b0, `CUA_OFF_RXSTAT, 32'h0);
    chk(rd & 32'h10, 32'h10, "stop error");
    chk(rx_interrupt, 1'b0, "irq cleared");
    far.brk();
    // Let the frame that follows the break finish before draining
    repeat (200) @(posedge clk);
    apb(1'b0, `CUA_OFF_RXSTAT, 32'h0);
    chk(rd & 32'h8, 32'h8, "break");
    repeat (4) apb(1'b0, `CUA_OFF_RXDATA, 32'h0);
    $display("test errors done");
    // Fill the receive FIFO, then one more
    apb(1'b1, `CUA_OFF_RXMASK, 32'h1);
    for (int i = 0; i < 5; i++) begin
      b[i] = 8'($urandom);
      far.send(b[i], 2'h0, 1'b0, 1'b1);
      if (i == 3) chk(rts_n, 1'b1, "rts full");
    end
    chk(rx_interrupt, 1'b1, "rx irq");
    apb(1'b0, `CUA_OFF_RXSTAT, 32'h0);
    chk(rd & 32'h41, 32'h41, "overrun");
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, `CUA_OFF_RXDATA, 32'h0);
      chk(rd & 32'hff, b[i], "fifo char");
    end
    chk(rts_n, 1'b0, "rts ready");
    chk(rx_interrupt, 1'b0, "rx irq off");
    $display("test overrun done");
    // Remote not ready: character must wait for clear-to-send
    cts_n <= 1'b1;
    apb(1'b1, `CUA_OFF_TXDATA, 32'ha5);
    repeat (100) @(posedge clk);
    chk(tx, 1'b1, "held by cts");
    cts_n <= 1'b0;
    for (int k = 0; k < 4000 && far.got.size() < 1; k++) @(posedge clk);
    chk(far.got[0], 8'ha5, "sent after cts");
    repeat (40) @(posedge clk);
    far.got.delete();
    $display("test flow control done");
    // Synchronous reset in the middle of a frame
    apb(1'b1, `CUA_OFF_TXDATA, 32'h0);
    wait (tx === 1'b0);
    repeat (20) @(posedge clk);
    sync_reset <= 1'b1;
    @(posedge clk);
    sync_reset <= 1'b0;
    repeat (2) @(posedge clk);
    chk(tx, 1'b1, "tx idle");
    repeat (200) @(posedge clk);
    far.got.delete();
    $display("test sync reset done");
    give_verdict();
  end
endmodule
